/* File: src/adc_mode_alarm_register_bank.sv */
// configuration bank: decodes serial frames into mode, scan, pin and threshold state.
// assumes the converter datapath hands results over on clk with their channel number,
// and that the serial pins and general-purpose pins are asynchronous to clk.
`timescale 1ns/1ps
module adc_mode_alarm_register_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input adc_cfg_pkg::conv_t conv,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output adc_cfg_pkg::mode_t mode,
    output logic [3:0] channel,
    output logic range_select,
    output logic power_down,
    output logic low_bit_out_enable,
    output adc_cfg_pkg::alarm_t alarm,
    output logic threshold_programming
);

    adc_cfg_pkg::frame_t frame;
    logic frame_done;
    adc_cfg_pkg::thr_wr_t thr_wr;
    logic soft_clear;

    logic [11:0] single_ctrl_r;
    logic [11:0] list_ctrl_r;
    logic [11:0] last_ctrl_r;
    logic [11:0] pinfn_r;
    logic [15:0] scan_channel_mask_r;
    logic [3:0] scan_last_channel_r;
    adc_cfg_pkg::mode_t mode_r;
    adc_cfg_pkg::seq_t seq_r;
    logic [1:0] group_r;
    logic [3:0] chan_r;
    logic [3:0] chan_nxt;
    logic [3:0] pin_data_r;
    logic reset_pending_r;
    logic [3:0] pin_sync1_r;
    logic [3:0] pin_sync2_r;
    logic [11:0] active_ctrl;
    logic cfg_write;
    logic counter_reset;

    serial_frame_rx u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdi(sdi),
        .frame(frame),
        .frame_done(frame_done)
    );

    // the register-reset request acts on the frame that follows it, which is
    // consumed by the reset and otherwise ignored
    assign soft_clear = frame_done && reset_pending_r;

    // any frame taken while the threshold sequence runs is a threshold write
    always_comb begin
        thr_wr.en = frame_done && !soft_clear && (seq_r == adc_cfg_pkg::SEQ_PROG);
        thr_wr.chan = {group_r, frame.code[3:2]};
        thr_wr.upper = frame.code[1];
        thr_wr.value = frame.body[adc_cfg_pkg::THR_MSB:0];
    end

    threshold_bank u_thr (
        .clk(clk),
        .rst_n(rst_n),
        .clear(soft_clear),
        .wr(thr_wr),
        .conv(conv),
        .alarm(alarm)
    );

    // configuration frames only count outside the threshold sequence
    assign cfg_write = frame_done && !soft_clear && (seq_r == adc_cfg_pkg::SEQ_IDLE);

    always_ff @(posedge clk) begin
        if (!rst_n || soft_clear) begin
            seq_r <= adc_cfg_pkg::SEQ_IDLE;
            group_r <= 2'h0;
        end else if (frame_done) begin
            unique case (seq_r)
                adc_cfg_pkg::SEQ_IDLE: begin
                    // codes 1100 to 1111: the low two bits name the group
                    if (frame.code[3:2] == adc_cfg_pkg::ALARM_CODE_PREFIX) begin
                        seq_r <= adc_cfg_pkg::SEQ_PROG;
                        group_r <= frame.code[1:0];
                    end
                end
                adc_cfg_pkg::SEQ_PROG: begin
                    if (frame.code[0]) begin
                        seq_r <= adc_cfg_pkg::SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || soft_clear) begin
            single_ctrl_r <= adc_cfg_pkg::CTRL_RST;
            list_ctrl_r <= adc_cfg_pkg::CTRL_RST;
            last_ctrl_r <= adc_cfg_pkg::CTRL_RST;
            pinfn_r <= adc_cfg_pkg::PINFN_RST;
            scan_channel_mask_r <= adc_cfg_pkg::LIST_SETUP_RST;
            scan_last_channel_r <= adc_cfg_pkg::LAST_CH_RST;
            mode_r <= adc_cfg_pkg::MODE_SINGLE;
        end else if (cfg_write) begin
            // the continue code and the reserved codes fall through untouched
            unique case (frame.code)
                adc_cfg_pkg::CODE_SINGLE: begin
                    single_ctrl_r <= frame.body;
                    mode_r <= adc_cfg_pkg::MODE_SINGLE;
                end
                adc_cfg_pkg::CODE_LIST: begin
                    list_ctrl_r <= frame.body;
                    mode_r <= adc_cfg_pkg::MODE_LIST;
                end
                adc_cfg_pkg::CODE_LAST: begin
                    last_ctrl_r <= frame.body;
                    mode_r <= adc_cfg_pkg::MODE_LAST;
                end
                adc_cfg_pkg::CODE_PINFN: begin
                    // the two top body bits must stay zero whatever is sent
                    pinfn_r <= {2'h0, frame.body[adc_cfg_pkg::REG_RST_POS:0]};
                end
                adc_cfg_pkg::CODE_LIST_SETUP: begin
                    scan_channel_mask_r <= frame;
                end
                adc_cfg_pkg::CODE_LAST_SETUP: begin
                    scan_last_channel_r <=
                        frame.body[adc_cfg_pkg::LAST_CH_MSB:adc_cfg_pkg::LAST_CH_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || soft_clear) begin
            reset_pending_r <= 1'b0;
        end else if (cfg_write && frame.code == adc_cfg_pkg::CODE_PINFN) begin
            reset_pending_r <= frame.body[adc_cfg_pkg::REG_RST_POS];
        end
    end

    // pin data is latched only from a control word that enables the update
    always_ff @(posedge clk) begin
        if (!rst_n || soft_clear) begin
            pin_data_r <= 4'h0;
        end else if (cfg_write && frame.body[adc_cfg_pkg::PIN_EN_POS]
                && (frame.code == adc_cfg_pkg::CODE_SINGLE
                || frame.code == adc_cfg_pkg::CODE_LIST
                || frame.code == adc_cfg_pkg::CODE_LAST)) begin
            pin_data_r <= frame.body[adc_cfg_pkg::PIN_DATA_MSB:0];
        end
    end

    always_comb begin
        unique case (mode_r)
            adc_cfg_pkg::MODE_SINGLE: active_ctrl = single_ctrl_r;
            adc_cfg_pkg::MODE_LIST: active_ctrl = list_ctrl_r;
            adc_cfg_pkg::MODE_LAST: active_ctrl = last_ctrl_r;
            default: active_ctrl = single_ctrl_r;
        endcase
    end

    // the counter-reset bit acts on the frame that carries it
    assign counter_reset = cfg_write && frame.body[adc_cfg_pkg::CNT_RST_POS]
        && (frame.code == adc_cfg_pkg::CODE_LIST
        || frame.code == adc_cfg_pkg::CODE_LAST);

    // next channel: scan-list seeks the next set mask bit, scan-to-last counts up
    always_comb begin
        logic found;
        logic [3:0] probe;
        found = 1'b0;
        probe = chan_r;
        chan_nxt = chan_r;
        unique case (mode_r)
            adc_cfg_pkg::MODE_LIST: begin
                for (int i = 1; i <= 16; i++) begin
                    probe = chan_r + 4'(i);
                    if (!found && scan_channel_mask_r[probe]) begin
                        chan_nxt = probe;
                        found = 1'b1;
                    end
                end
            end
            adc_cfg_pkg::MODE_LAST: begin
                if (chan_r == scan_last_channel_r) begin
                    chan_nxt = adc_cfg_pkg::CHAN_ZERO;
                end else begin
                    chan_nxt = chan_r + 4'h1;
                end
            end
            default: begin
                chan_nxt = single_ctrl_r[adc_cfg_pkg::CHAN_MSB:adc_cfg_pkg::CHAN_LSB];
            end
        endcase
    end

    // scan modes take one step per completed frame, the continue code included; single mode follows its control word
    always_ff @(posedge clk) begin
        if (!rst_n || soft_clear) begin
            chan_r <= adc_cfg_pkg::CHAN_ZERO;
        end else if (counter_reset) begin
            chan_r <= adc_cfg_pkg::CHAN_ZERO;
        end else if (frame_done && mode_r != adc_cfg_pkg::MODE_SINGLE) begin
            chan_r <= chan_nxt;
        end else if (mode_r == adc_cfg_pkg::MODE_SINGLE) begin
            chan_r <= chan_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_sync1_r <= 4'h0;
            pin_sync2_r <= 4'h0;
        end else begin
            pin_sync1_r <= pin_in;
            pin_sync2_r <= pin_sync1_r;
        end
    end

    // pins with a fixed function override the direction bits
    always_comb begin
        pin_oe = pinfn_r[adc_cfg_pkg::DIR_MSB:0];
        pin_out = pin_data_r;
        if (pinfn_r[adc_cfg_pkg::PIN3_PD_POS]) begin
            pin_oe[3] = 1'b0;
        end
        if (pinfn_r[adc_cfg_pkg::PIN2_RANGE_POS]) begin
            pin_oe[2] = 1'b0;
        end
        if (pinfn_r[adc_cfg_pkg::ALARM_CFG_LSB]) begin
            pin_oe[0] = 1'b1;
            pin_out[0] = alarm.high | alarm.low;
        end else if (pinfn_r[adc_cfg_pkg::ALARM_CFG_LSB + 1]) begin
            pin_oe[0] = 1'b1;
            pin_out[0] = alarm.high;
        end
        if (pinfn_r[adc_cfg_pkg::ALARM_CFG_MSB]) begin
            pin_oe[1] = 1'b1;
            pin_out[1] = alarm.low;
        end
    end

    // the power-down pin is active low; the range pin high selects the wide range
    assign power_down = pinfn_r[adc_cfg_pkg::PIN3_PD_POS] ? !pin_sync2_r[3]
        : active_ctrl[adc_cfg_pkg::PD_POS];
    assign range_select = pinfn_r[adc_cfg_pkg::PIN2_RANGE_POS] ? pin_sync2_r[2]
        : active_ctrl[adc_cfg_pkg::RANGE_POS];
    assign low_bit_out_enable = active_ctrl[adc_cfg_pkg::LOW_BIT_EN_POS];
    assign mode = mode_r;
    assign channel = chan_r;
    assign threshold_programming = (seq_r == adc_cfg_pkg::SEQ_PROG);

endmodule : adc_mode_alarm_register_bank

/* File: src/adc_cfg_pkg.sv */
// constants, field positions, reset values and carrier types for the
// serial-programmed configuration bank of a sixteen-channel sampling converter.
// assumes a single 250 MHz clock domain; the serial link is sampled, not clocked.
//
// Overview of operation
// - each channel's upper threshold is 10 bits and resets to all ones
// - each channel's lower threshold is 10 bits and resets to zero
// - code 1101 programs group one: sub-address picks channels four to seven
// - codes 1110 and 1111 program groups two and three: channels 8-11, 12-15
// - single-channel control word at code 0001, reset zero, documented field layout
// - scan-list control word at code 0010, reset zero, counter reset at bit 10
// - scan-to-last control word at code 0011 shares the scan-list layout
// - pin-function word at code 0100: register reset, pin roles, alarm pins, directions
// - scan-list setup at code 1000 holds sixteen channel bits, all reset to one
// - scan-to-last setup at code 1001 keeps last channel in bits 9:6, reset ones
// - threshold frames: channel low bits, upper select, exit flag, 10-bit value
// - code 0000 writes no register and its lower twelve bits are ignored; in scan modes it still steps the channel
// - thresholds compare to result bits 11:2; above upper or below lower alarms
// - threshold programming ends only after a frame with bit 12 set
// - scan-to-last counter runs from zero to the last channel, then wraps
package adc_cfg_pkg;

    localparam int FRAME_BITS = 16;

    localparam logic [3:0] CODE_CONTINUE = 4'h0;
    localparam logic [3:0] CODE_SINGLE = 4'h1;
    localparam logic [3:0] CODE_LIST = 4'h2;
    localparam logic [3:0] CODE_LAST = 4'h3;
    localparam logic [3:0] CODE_PINFN = 4'h4;
    localparam logic [3:0] CODE_LIST_SETUP = 4'h8;
    localparam logic [3:0] CODE_LAST_SETUP = 4'h9;
    localparam logic [3:0] CODE_ALARM_G0 = 4'hC;
    localparam logic [3:0] CODE_ALARM_G1 = 4'hD;
    localparam logic [3:0] CODE_ALARM_G2 = 4'hE;
    localparam logic [3:0] CODE_ALARM_G3 = 4'hF;
    localparam logic [1:0] ALARM_CODE_PREFIX = 2'h3;

    // control word fields, positions within the 12-bit frame body
    localparam int LOW_BIT_EN_POS = 11;
    localparam int CHAN_MSB = 10;
    localparam int CHAN_LSB = 7;
    localparam int CNT_RST_POS = 10;
    localparam int RANGE_POS = 6;
    localparam int PD_POS = 5;
    localparam int PIN_EN_POS = 4;
    localparam int PIN_DATA_MSB = 3;

    // pin-function word fields
    localparam int FIXED_MSB = 11;
    localparam int FIXED_LSB = 10;
    localparam int REG_RST_POS = 9;
    localparam int PIN3_PD_POS = 8;
    localparam int PIN2_RANGE_POS = 7;
    localparam int ALARM_CFG_MSB = 6;
    localparam int ALARM_CFG_LSB = 4;
    localparam int DIR_MSB = 3;

    // scan-to-last setup field
    localparam int LAST_CH_MSB = 9;
    localparam int LAST_CH_LSB = 6;

    // threshold frame fields, positions within the full 16-bit frame
    localparam int THR_CH_MSB = 15;
    localparam int THR_CH_LSB = 14;
    localparam int THR_UPPER_POS = 13;
    localparam int THR_EXIT_POS = 12;
    localparam int THR_MSB = 9;

    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [11:0] PINFN_RST = 12'h000;
    localparam logic [15:0] LIST_SETUP_RST = 16'hFFFF;
    localparam logic [3:0] LAST_CH_RST = 4'hF;
    localparam logic [9:0] UPPER_THR_RST = 10'h3FF;
    localparam logic [9:0] LOWER_THR_RST = 10'h000;
    localparam logic [3:0] CHAN_ZERO = 4'h0;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b01,
        MODE_LIST = 2'b10,
        MODE_LAST = 2'b11
    } mode_t;

    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_PROG = 1'b1
    } seq_t;

    typedef struct packed {
        logic [3:0] code;
        logic [11:0] body;
    } frame_t;

    typedef struct packed {
        logic en;
        logic [3:0] chan;
        logic upper;
        logic [9:0] value;
    } thr_wr_t;

    typedef struct packed {
        logic valid;
        logic [3:0] channel;
        logic [11:0] result;
    } conv_t;

    typedef struct packed {
        logic high;
        logic low;
    } alarm_t;

endpackage : adc_cfg_pkg

/* File: src/serial_frame_rx.sv */
// serial frame receiver: samples chip select, serial clock and data pins.
// assumes all three pins are asynchronous to clk and the serial clock
// is well below a quarter of clk, so its edges are found by sampling.
`timescale 1ns/1ps
module serial_frame_rx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output adc_cfg_pkg::frame_t frame,
    output logic frame_done
);

    logic [1:0] cs_sync_r;
    logic [1:0] sclk_sync_r;
    logic [1:0] sdi_sync_r;
    logic cs_prev_r;
    logic sclk_prev_r;
    logic [15:0] shift_r;
    logic [4:0] count_r;
    logic done_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_sync_r <= 2'h3;
            sclk_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
            cs_prev_r <= 1'b1;
            sclk_prev_r <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], cs_n};
            sclk_sync_r <= {sclk_sync_r[0], sclk};
            sdi_sync_r <= {sdi_sync_r[0], sdi};
            cs_prev_r <= cs_sync_r[1];
            sclk_prev_r <= sclk_sync_r[1];
        end
    end

    // data is taken on the rising serial clock, msb first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_r <= 16'h0000;
            count_r <= 5'h00;
        end else if (cs_sync_r[1]) begin
            count_r <= 5'h00;
        end else if (sclk_sync_r[1] && !sclk_prev_r) begin
            shift_r <= {shift_r[14:0], sdi_sync_r[1]};
            if (count_r != 5'h1F) begin
                count_r <= count_r + 5'h01;
            end
        end
    end

    // a frame of the wrong length is dropped whole on release of chip select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= cs_sync_r[1] && !cs_prev_r
                && (count_r == 5'(adc_cfg_pkg::FRAME_BITS));
        end
    end

    assign frame = adc_cfg_pkg::frame_t'(shift_r);
    assign frame_done = done_r;

endmodule : serial_frame_rx

/* File: src/threshold_bank.sv */
// per-channel upper and lower alarm thresholds with the result comparator.
// assumes writes and conversion results arrive on clk; clear is a one-cycle pulse.
`timescale 1ns/1ps
module threshold_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input adc_cfg_pkg::thr_wr_t wr,
    input adc_cfg_pkg::conv_t conv,
    output adc_cfg_pkg::alarm_t alarm
);

    logic [9:0] upper_thr_r [16];
    logic [9:0] lower_thr_r [16];
    adc_cfg_pkg::alarm_t alarm_r;
    logic [9:0] top_bits;

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            for (int i = 0; i < 16; i++) begin
                upper_thr_r[i] <= adc_cfg_pkg::UPPER_THR_RST;
                lower_thr_r[i] <= adc_cfg_pkg::LOWER_THR_RST;
            end
        end else if (wr.en) begin
            if (wr.upper) begin
                upper_thr_r[wr.chan] <= wr.value;
            end else begin
                lower_thr_r[wr.chan] <= wr.value;
            end
        end
    end

    // only the upper ten result bits take part in the compare
    assign top_bits = conv.result[11:2];

    // alarm holds the verdict on the most recent result until the next one
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            alarm_r <= '0;
        end else if (conv.valid) begin
            alarm_r.high <= top_bits > upper_thr_r[conv.channel];
            alarm_r.low <= top_bits < lower_thr_r[conv.channel];
        end
    end

    assign alarm = alarm_r;

endmodule : threshold_bank

/* File: tb/host_serial_model.sv */
// host model: shapes frames on chip select, serial clock and data pins.
// assumes a 4 ns bench clock; the serial clock runs at 32 ns inside frames only.
`timescale 1ns/1ps
module host_serial_model (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // msb first, data set while the serial clock is low
    task automatic send_bits(input logic [15:0] f, input int n);
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdi = f[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (2) @(negedge clk);
        cs_n = 1'b1;
        // released data line must not look like a held bit
        sdi = ~sdi;
        // gap lets the device take the frame before the next one
        repeat (10) @(negedge clk);
    endtask : send_bits
endmodule : host_serial_model

/* File: tb/adc_mode_alarm_register_bank_chk.sv */
// checker: ties changes of mode, channel, sequence flag, pin enables and low-bit enable to the close of a serial frame.
// assumes the bind below and that settings land a few clk after chip select rises.
`timescale 1ns/1ps
module adc_mode_alarm_register_bank_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input adc_cfg_pkg::conv_t conv,
    input adc_cfg_pkg::mode_t mode,
    input wire logic [3:0] channel,
    input wire logic [3:0] pin_oe,
    input wire logic low_bit_out_enable,
    input adc_cfg_pkg::alarm_t alarm,
    input wire logic threshold_programming
);
    logic [3:0] high_cnt_r;
    logic settle;

    // cycles since chip select went high, saturating
    always_ff @(posedge clk) begin
        if (!rst_n || !cs_n) begin
            high_cnt_r <= 4'h0;
        end else if (high_cnt_r != 4'hF) begin
            high_cnt_r <= high_cnt_r + 4'h1;
        end
    end
    assign settle = (high_cnt_r >= 4'h3) && (high_cnt_r <= 4'h8);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    mode_update_a: assert property ($changed(mode) |-> settle)
        else $error("mode changed outside frame completion");
    chan_update_a: assert property ($changed(channel) |-> settle)
        else $error("channel changed outside frame completion");
    seq_update_a: assert property ($changed(threshold_programming) |-> settle)
        else $error("threshold sequence flag changed outside frame completion");
    oe_update_a: assert property ($changed(pin_oe) |-> settle)
        else $error("pin enables changed outside frame completion");
    lowbit_update_a: assert property ($changed(low_bit_out_enable) |-> settle)
        else $error("low bit enable changed outside frame completion");
    reset_state_a: assert property (!$past(rst_n) |->
        mode == adc_cfg_pkg::MODE_SINGLE && channel == 4'h0 && !threshold_programming)
        else $error("state after reset is not the reset state");
    // a full scale result can never sit below a lower threshold, whatever is programmed
    upper_max_a: assert property (conv.valid && conv.result[11:2] == 10'h3FF
        |-> ##1 !alarm.low)
        else $error("lower alarm on a full scale result");
    // a zero result can never sit above an upper threshold
    lower_zero_a: assert property (conv.valid && conv.result[11:2] == 10'h000
        |-> ##1 !alarm.high)
        else $error("upper alarm on a zero result");
    alarm_cause_a: assert property ($changed(alarm) |->
        $past(conv.valid) || $past(conv.valid, 2) || settle)
        else $error("alarm changed without a result or frame");
endmodule : adc_mode_alarm_register_bank_chk

bind adc_mode_alarm_register_bank adc_mode_alarm_register_bank_chk chk_u (
    .clk, .rst_n, .cs_n, .conv, .mode, .channel, .pin_oe, .low_bit_out_enable,
    .alarm, .threshold_programming
);

/* File: tb/adc_mode_alarm_register_bank_test.sv */
// testbench: programs the bank through the host model and judges the ports.
// assumes settings land within 10 clk of the frame end.
`timescale 1ns/1ps
module adc_mode_alarm_register_bank_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk, sdi;
    adc_cfg_pkg::conv_t conv = '0;
    logic [3:0] pin_in = 4'h0;
    logic [3:0] pin_out, pin_oe, channel;
    adc_cfg_pkg::mode_t mode;
    logic range_select, power_down, low_bit_out_enable, threshold_programming;
    adc_cfg_pkg::alarm_t alarm;
    int failures = 0;
    int comparisons = 0;

    always #2 clk = ~clk;

    host_serial_model host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

    adc_mode_alarm_register_bank dut_u (
        .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .conv(conv),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mode(mode),
        .channel(channel), .range_select(range_select), .power_down(power_down),
        .low_bit_out_enable(low_bit_out_enable), .alarm(alarm),
        .threshold_programming(threshold_programming)
    );

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic frame(input logic [15:0] f);
        host_u.send_bits(f, 16);
    endtask : frame

    // alarm is looked at once the result has had two edges to land
    task automatic convert(input logic [3:0] ch, input logic [11:0] res, input logic [1:0] exp);
        @(negedge clk);
        conv = {1'b1, ch, res};
        @(negedge clk);
        conv.valid = 1'b0;
        @(negedge clk);
        chk("alarm", 16'(exp), 16'(alarm));
    endtask : convert

    task automatic check_reset_values();
        chk("mode", 16'h1, 16'(mode));
        chk("channel", 16'h0, 16'(channel));
        chk("pin_oe", 16'h0, 16'(pin_oe));
        chk("pin_out", 16'h0, 16'(pin_out));
        chk("flags", 16'h0, 16'({range_select, power_down, low_bit_out_enable}));
        chk("seq", 16'h0, 16'(threshold_programming));
        convert(4'h0, 12'hFFF, 2'b00);
        convert(4'h0, 12'h000, 2'b00);
    endtask : check_reset_values

    task automatic single_and_pins();
        frame(16'h1AFA);
        chk("channel", 16'h5, 16'(channel));
        chk("flags", 16'h7, 16'({range_select, power_down, low_bit_out_enable}));
        frame(16'h400F);
        chk("pin_oe", 16'hF, 16'(pin_oe));
        chk("pin_out", 16'hA, 16'(pin_out));
        frame(16'h0FFF);
        chk("channel", 16'h5, 16'(channel));
        chk("pin_out", 16'hA, 16'(pin_out));
        host_u.send_bits(16'h1000, 8);
        chk("channel", 16'h5, 16'(channel));
        // taken whole, the cut frame would read as a threshold-sequence code
        chk("seq", 16'h0, 16'(threshold_programming));
        pin_in = 4'h4;
        frame(16'h4080);
        chk("range", 16'h1, 16'(range_select));
        pin_in = 4'h0;
        repeat (6) @(negedge clk);
        chk("range", 16'h0, 16'(range_select));
    endtask : single_and_pins

    task automatic scan_modes();
        frame(16'h9080);
        frame(16'h3400);
        chk("mode", 16'h3, 16'(mode));
        chk("channel", 16'h0, 16'(channel));
        for (int i = 1; i <= 4; i++) begin
            frame(16'h0000);
            chk("channel", 16'(i % 3), 16'(channel));
        end
        frame(16'h2400);
        chk("mode", 16'h2, 16'(mode));
        chk("channel", 16'h0, 16'(channel));
        frame(16'h0000);
        chk("channel", 16'h1, 16'(channel));
        frame(16'h0000);
        chk("channel", 16'h2, 16'(channel));
        // new mask keeps channels 15, 2 and 0; this frame still steps on the old mask
        frame(16'h8005);
        chk("channel", 16'h3, 16'(channel));
        frame(16'h0000);
        chk("channel", 16'hF, 16'(channel));
        frame(16'h0000);
        chk("channel", 16'h0, 16'(channel));
    endtask : scan_modes

    task automatic thresholds();
        frame(16'hD000);
        chk("seq", 16'h1, 16'(threshold_programming));
        frame(16'h6100);
        chk("seq", 16'h1, 16'(threshold_programming));
        frame(16'h5080);
        chk("seq", 16'h0, 16'(threshold_programming));
        convert(4'h5, 12'h404, 2'b10);
        convert(4'h5, 12'h400, 2'b00);
        convert(4'h5, 12'h1FC, 2'b01);
        convert(4'h4, 12'h404, 2'b00);
        frame(16'hE000);
        frame(16'h7010);
        convert(4'h9, 12'h044, 2'b10);
        frame(16'hF000);
        frame(16'h9200);
        convert(4'hE, 12'h400, 2'b01);
        // pin0 becomes the combined alarm output; pins 3:1 keep the latched data
        frame(16'h4011);
        convert(4'hE, 12'h400, 2'b01);
        chk("pin_oe", 16'h1, 16'(pin_oe));
        chk("pin_out", 16'hB, 16'(pin_out));
    endtask : thresholds

    task automatic soft_reset();
        frame(16'h4200);
        frame(16'h1780);
        chk("channel", 16'h0, 16'(channel));
        chk("mode", 16'h1, 16'(mode));
        chk("pin_oe", 16'h0, 16'(pin_oe));
        convert(4'h5, 12'h404, 2'b00);
    endtask : soft_reset

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check_reset_values();
        single_and_pins();
        scan_modes();
        thresholds();
        soft_reset();
        give_verdict();
    end

    // a hang counts against the run and still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule : adc_mode_alarm_register_bank_test
